// file: logic/prsq_pkg.sv
// package for the phy reset and isolate sequencer: timing constants, states, carriers
// assumes a 40 MHz reference clock feeding the sequencer
`default_nettype none
package prsq_pkg;
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned HW_RESET_MIN_NS = 1000;
    localparam int unsigned HW_RESET_MIN_CYC = (HW_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int unsigned STRAP_LATCH_NS = 800;
    localparam int unsigned STRAP_LATCH_CYC = (STRAP_LATCH_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned ISO_CLEAR_MAX_US = 100;
    localparam int unsigned ISO_CLEAR_CYC = (ISO_CLEAR_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned INT_RESET_US = 500;
    localparam int unsigned INT_RESET_CYC = (INT_RESET_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned MGMT_PREAMBLE_BITS = 32;
    localparam int unsigned ISOLATE_BIT = 10;
    localparam int unsigned STRAP_W = 5;
    localparam int unsigned CNT_W = 20;
    localparam logic [4:0] ADDR_ZERO = 5'h00;
    localparam logic [2:0] FILT_ONES = 3'h7;

    typedef enum logic [2:0] {
        PRSQ_ST_RESET = 3'h0,
        PRSQ_ST_LATCH = 3'h1,
        PRSQ_ST_SETTLE = 3'h2,
        PRSQ_ST_ISOLATE = 3'h3,
        PRSQ_ST_LEAVE = 3'h4,
        PRSQ_ST_NORMAL = 3'h5
    } prsq_state_t;

    typedef struct packed {
        logic isolate;
        logic soft_reset;
    } prsq_ctrl_t;

    typedef struct packed {
        logic busy;
        logic isolated;
        logic mgmt_ready;
        logic [4:0] strap_addr;
    } prsq_stat_t;
endpackage
`default_nettype wire

// file: logic/prsq_filter.sv
// three-stage pin synchroniser with agreement filter
// assumes the pin is asynchronous to ref_clk_in
`default_nettype none
module prsq_filter #(
    parameter int unsigned RESET_VAL = 0
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    output logic level_out
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;

    always_comb begin
        sync_d = {sync_q[1:0], pin_in};
        level_d = level_q;
        // stage 0 is only read by stage 1
        if (sync_q[1] == sync_q[2]) begin
            level_d = sync_q[2];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sync_q <= {3{RESET_VAL[0]}};
            level_q <= RESET_VAL[0];
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;
endmodule
`default_nettype wire

// file: logic/prsq_sequencer.sv
// reset, strap latch and isolate sequencing for a 10/100 ethernet phy
// assumes ref_clk_in at 40 MHz; reset pin asynchronous; strap pins shared with outputs
`default_nettype none
module prsq_sequencer #(
    parameter int unsigned INT_RESET_CYCLES = prsq_pkg::INT_RESET_CYC,
    parameter int unsigned ISO_CLEAR_CYCLES = prsq_pkg::ISO_CLEAR_CYC
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic hw_reset_pin_in,
    input wire prsq_pkg::prsq_ctrl_t ctrl_in,
    input wire logic ctrl_write_in,
    input wire logic mdc_rise_in,
    input wire logic mdio_in,
    input wire logic [4:0] strap_pins_in,
    input wire logic [4:0] pin_drive_in,
    output logic [4:0] strap_pins_out,
    output logic strap_pins_oe_n_out,
    output logic regs_default_out,
    output logic frame_accept_out,
    output prsq_pkg::prsq_stat_t status_out
);
    logic pin_level;
    logic [prsq_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [prsq_pkg::CNT_W-1:0] hold_q, hold_d;
    logic [5:0] pre_q, pre_d;
    prsq_pkg::prsq_state_t state_q, state_d;
    logic [4:0] addr_q, addr_d;
    logic [4:0] pins_q, pins_d;
    logic oe_n_q, oe_n_d;
    logic iso_q, iso_d;
    logic dflt_q, dflt_d;
    logic acc_q, acc_d;
    logic rst_req;
    logic [prsq_pkg::STRAP_W-1:0] strap_level;

    function automatic logic [prsq_pkg::CNT_W-1:0] cyc(input int unsigned n);
        cyc = prsq_pkg::CNT_W'(n);
    endfunction

    prsq_filter #(.RESET_VAL(0)) u_rst_filt (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .pin_in(hw_reset_pin_in),
        .level_out(pin_level)
    );

    // straps settle through resistors once the pins turn back into inputs, so they are
    // filtered like the reset pin; the 32-cycle latch delay leaves ample time for that
    for (genvar b = 0; b < int'(prsq_pkg::STRAP_W); b++) begin : g_strap
        prsq_filter #(.RESET_VAL(0)) u_strap_filt (
            .ref_clk_in(ref_clk_in),
            .reset_in(reset_in),
            .pin_in(strap_pins_in[b]),
            .level_out(strap_level[b])
        );
    end

    always_comb begin
        // short glitches never reach the sequencer
        hold_d = pin_level ? ((hold_q == cyc(prsq_pkg::HW_RESET_MIN_CYC)) ? hold_q
            : hold_q + 1'b1) : '0;
    end

    // hard reset only counts after the minimum width; soft reset takes effect at once
    assign rst_req = (hold_q == cyc(prsq_pkg::HW_RESET_MIN_CYC))
        || (ctrl_write_in && ctrl_in.soft_reset);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        pins_d = pins_q;
        oe_n_d = oe_n_q;
        iso_d = iso_q;
        dflt_d = 1'b0;
        if (rst_req) begin
            state_d = prsq_pkg::PRSQ_ST_RESET;
            oe_n_d = 1'b1;
            iso_d = 1'b1;
            cnt_d = '0;
        end else begin
            unique case (state_q)
                prsq_pkg::PRSQ_ST_RESET: begin
                    oe_n_d = 1'b1;
                    iso_d = 1'b1;
                    if (!pin_level) begin
                        state_d = prsq_pkg::PRSQ_ST_LATCH;
                        cnt_d = '0;
                    end
                end
                prsq_pkg::PRSQ_ST_LATCH: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == cyc(prsq_pkg::STRAP_LATCH_CYC - 1)) begin
                        addr_d = strap_level;
                        oe_n_d = 1'b0;
                        state_d = prsq_pkg::PRSQ_ST_SETTLE;
                    end
                end
                prsq_pkg::PRSQ_ST_SETTLE: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q >= cyc(INT_RESET_CYCLES - 1)) begin
                        dflt_d = 1'b1;
                        state_d = prsq_pkg::PRSQ_ST_ISOLATE;
                        // address zero stays isolated until software clears the bit
                        if (addr_q != prsq_pkg::ADDR_ZERO) begin
                            iso_d = 1'b0;
                            state_d = prsq_pkg::PRSQ_ST_NORMAL;
                        end
                    end
                end
                prsq_pkg::PRSQ_ST_ISOLATE: begin
                    if (ctrl_write_in && !ctrl_in.isolate) begin
                        state_d = prsq_pkg::PRSQ_ST_LEAVE;
                        cnt_d = '0;
                    end
                end
                prsq_pkg::PRSQ_ST_LEAVE: begin
                    cnt_d = cnt_q + 1'b1;
                    if (ctrl_write_in && ctrl_in.isolate) begin
                        state_d = prsq_pkg::PRSQ_ST_ISOLATE;
                    end else if (cnt_q >= cyc(ISO_CLEAR_CYCLES - 1)) begin
                        iso_d = 1'b0;
                        state_d = prsq_pkg::PRSQ_ST_NORMAL;
                    end
                end
                prsq_pkg::PRSQ_ST_NORMAL: begin
                    if (ctrl_write_in && ctrl_in.isolate) begin
                        iso_d = 1'b1;
                        state_d = prsq_pkg::PRSQ_ST_ISOLATE;
                    end
                end
                default: begin
                    state_d = prsq_pkg::PRSQ_ST_RESET;
                    iso_d = 1'b1;
                    oe_n_d = 1'b1;
                end
            endcase
        end
        pins_d = pin_drive_in;
    end

    logic busy;
    assign busy = (state_q == prsq_pkg::PRSQ_ST_RESET) || (state_q == prsq_pkg::PRSQ_ST_LATCH)
        || (state_q == prsq_pkg::PRSQ_ST_SETTLE);

    always_comb begin
        pre_d = pre_q;
        acc_d = acc_q;
        if (busy || rst_req) begin
            pre_d = '0;
            acc_d = 1'b0;
        end else if (mdc_rise_in) begin
            if (!mdio_in) begin
                pre_d = '0;
            end else if (pre_q != 6'(prsq_pkg::MGMT_PREAMBLE_BITS)) begin
                pre_d = pre_q + 1'b1;
            end
            if (pre_q == 6'(prsq_pkg::MGMT_PREAMBLE_BITS - 1) && mdio_in) begin
                acc_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_q <= prsq_pkg::PRSQ_ST_RESET;
            cnt_q <= '0;
            hold_q <= '0;
            pre_q <= '0;
            addr_q <= '0;
            pins_q <= '0;
            oe_n_q <= 1'b1;
            iso_q <= 1'b1;
            dflt_q <= 1'b0;
            acc_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            pre_q <= pre_d;
            addr_q <= addr_d;
            pins_q <= pins_d;
            oe_n_q <= oe_n_d;
            iso_q <= iso_d;
            dflt_q <= dflt_d;
            acc_q <= acc_d;
        end
    end

    prsq_pkg::prsq_stat_t stat_q;
    prsq_pkg::prsq_stat_t stat_d;

    // isolated and ready follow the next values so the word lines up with the other outputs
    always_comb begin
        stat_d = '{busy: busy, isolated: iso_d, mgmt_ready: acc_d, strap_addr: addr_d};
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stat_q <= '{busy: 1'b1, isolated: 1'b1, mgmt_ready: 1'b0, strap_addr: 5'h00};
        end else begin
            stat_q <= stat_d;
        end
    end

    assign strap_pins_out = pins_q;
    assign strap_pins_oe_n_out = oe_n_q;
    assign regs_default_out = dflt_q;
    assign frame_accept_out = acc_q;
    assign status_out = stat_q;
endmodule
`default_nettype wire

// file: verif/prsq_props.sv
// port checker for the reset and isolate sequencer
// assumes it is bound onto prsq_sequencer with scaled counts
`default_nettype none
module prsq_props (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire prsq_pkg::prsq_ctrl_t ctrl_in,
    input wire logic ctrl_write_in,
    input wire logic mdc_rise_in,
    input wire logic mdio_in,
    input wire logic [4:0] pin_drive_in,
    input wire logic [4:0] strap_pins_out,
    input wire logic strap_pins_oe_n_out,
    input wire logic regs_default_out,
    input wire logic frame_accept_out,
    input wire prsq_pkg::prsq_stat_t status_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    logic [5:0] ones_q, ones_d;
    always_comb begin
        ones_d = ones_q;
        if (mdc_rise_in) begin
            ones_d = !mdio_in ? 6'h00 : (ones_q == 6'h3f) ? ones_q : ones_q + 6'h01;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        ones_q <= reset_in ? 6'h00 : ones_d;
    end
    full_preamble_a: assert property ($rose(frame_accept_out) |-> ones_q >= 6'h20)
        else $error("frame accept before a full preamble");
    busy_refuse_a: assert property (frame_accept_out |-> !status_out.busy)
        else $error("frames accepted while busy");
    default_pulse_a: assert property (regs_default_out |=> !regs_default_out)
        else $error("default pulse longer than one cycle");
    drive_late_a: assert property ($fell(reset_in) |-> strap_pins_oe_n_out[*8])
        else $error("strap pins driven before latching");
    reenter_hold_a: assert property ($rose(strap_pins_oe_n_out) |-> strap_pins_oe_n_out[*8])
        else $error("strap pins driven soon after a reset");
    drive_busy_a: assert property ($fell(strap_pins_oe_n_out) |-> status_out.busy)
        else $error("strap pins turned outward outside the sequence");
    pin_follow_a: assert property (!strap_pins_oe_n_out && !$past(strap_pins_oe_n_out)
        |-> strap_pins_out == $past(pin_drive_in))
        else $error("strap pins not following drive value");
    addr_hold_a: assert property (!status_out.busy && !$past(status_out.busy)
        |-> $stable(status_out.strap_addr))
        else $error("latched address changed outside reset");
    leave_iso_a: assert property ($rose(regs_default_out) && status_out.strap_addr != 5'h00
        |-> ##[0:3] !status_out.isolated)
        else $error("nonzero address stayed isolated");
    clear_iso_a: assert property (ctrl_write_in && ctrl_in == 2'h0 && status_out.isolated
        && !status_out.busy |=> status_out.isolated[*8] ##[1:16] !status_out.isolated)
        else $error("isolate clear timing wrong");
    cover property ($rose(frame_accept_out));
    cover property ($rose(regs_default_out) && status_out.strap_addr == 5'h00);
    cover property ($fell(status_out.isolated) && !status_out.busy);
    cover property (ctrl_write_in && ctrl_in.isolate && !status_out.isolated);
endmodule
bind prsq_sequencer prsq_props prsq_props_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .ctrl_in(ctrl_in), .ctrl_write_in(ctrl_write_in), .mdc_rise_in(mdc_rise_in),
    .mdio_in(mdio_in), .pin_drive_in(pin_drive_in), .strap_pins_out(strap_pins_out),
    .strap_pins_oe_n_out(strap_pins_oe_n_out), .regs_default_out(regs_default_out),
    .frame_accept_out(frame_accept_out), .status_out(status_out));
`default_nettype wire

// file: verif/prsq_host.sv
// host side model: drives the hardware reset pin and the management preamble
// assumes tasks are called from one bench process just after a clock edge
`default_nettype none
module prsq_host (
    input wire logic ref_clk_in,
    output logic hw_reset_pin_out,
    output logic mdc_rise_out,
    output logic mdio_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hw_reset_pin_out = 1'b0;
        mdc_rise_out = 1'b0;
        mdio_out = 1'b1;
    end
    // callers may send a preamble straight after a reset; the sequencer refuses frames while busy
    task automatic hold_reset(input int n);
        hw_reset_pin_out <= 1'b1;
        repeat (n) @(posedge ref_clk_in);
        hw_reset_pin_out <= 1'b0;
    endtask
    task automatic preamble(input int n, input logic level);
        mdio_out <= level;
        repeat (n) begin
            @(posedge ref_clk_in);
            mdc_rise_out <= 1'b1;
            @(posedge ref_clk_in);
            mdc_rise_out <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: verif/tb_phy_reset_isolate_sequencer.sv
// self-checking bench for the reset and isolate sequencer
// assumes scaled counts: 100 cycles internal reset, 20 cycles isolate exit
`default_nettype none
module tb_phy_reset_isolate_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, pin, mdc, mdio, oe_n, dflt, acc;
    logic [4:0] strap, drive, pout, pins;
    logic [31:0] lfsr;
    prsq_pkg::prsq_ctrl_t ctrl;
    prsq_pkg::prsq_stat_t st;
    int bad_count, n_checks;
    logic [4:0] exp_q[$];
    assign pins = oe_n ? strap : pout;
    prsq_host prsq_host_i (.ref_clk_in(clk), .hw_reset_pin_out(pin), .mdc_rise_out(mdc),
        .mdio_out(mdio));
    prsq_sequencer #(.INT_RESET_CYCLES(100), .ISO_CLEAR_CYCLES(20)) prsq_sequencer_i (
        .ref_clk_in(clk), .reset_in(rst), .hw_reset_pin_in(pin), .ctrl_in(ctrl),
        .ctrl_write_in(wr), .mdc_rise_in(mdc), .mdio_in(mdio), .strap_pins_in(pins),
        .pin_drive_in(drive), .strap_pins_out(pout), .strap_pins_oe_n_out(oe_n),
        .regs_default_out(dflt), .frame_accept_out(acc), .status_out(st));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_idle();
        repeat (4) @(posedge clk);
        for (int k = 0; k < 400 && st.busy !== 1'b0; k++) @(posedge clk);
        chk("busy", 8'h00, {7'h0, st.busy});
        repeat (4) @(posedge clk);
    endtask
    task automatic new_strap();
        lfsr = nxt(lfsr);
        strap <= lfsr[4:0] | 5'h01;
        drive <= lfsr[12:8];
        exp_q.push_back(lfsr[4:0] | 5'h01);
    endtask
    task automatic write_ctrl(input logic [1:0] v);
        ctrl <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (!rst && dflt === 1'b1) begin
            if (exp_q.size() == 0)
                chk("queue", 8'h01, 8'h00);
            else
                chk("strap_addr", {3'h0, exp_q.pop_front()}, {3'h0, st.strap_addr});
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        ctrl = 2'h0;
        drive = 5'h00;
        bad_count = 0;
        n_checks = 0;
        lfsr = 32'h5273;
        new_strap();
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_idle();
        chk("isolated", 8'h00, {7'h0, st.isolated});
        chk("oe_n", 8'h00, {7'h0, oe_n});
        lfsr = nxt(lfsr);
        drive <= lfsr[9:5];
        repeat (2) @(posedge clk);
        chk("pins_out", {3'h0, lfsr[9:5]}, {3'h0, pout});
        prsq_host_i.hold_reset(10);
        repeat (10) @(posedge clk);
        chk("short_pulse", 8'h00, {7'h0, st.busy});
        prsq_host_i.preamble(20, 1'b1);
        prsq_host_i.preamble(1, 1'b0);
        prsq_host_i.preamble(31, 1'b1);
        repeat (3) @(posedge clk);
        chk("accept_31", 8'h00, {6'h0, st.mgmt_ready, acc});
        prsq_host_i.preamble(1, 1'b1);
        repeat (3) @(posedge clk);
        chk("accept_32", 8'h03, {6'h0, st.mgmt_ready, acc});
        strap <= 5'h00;
        exp_q.push_back(5'h00);
        prsq_host_i.hold_reset(50);
        prsq_host_i.preamble(32, 1'b1);
        chk("busy_frame", 8'h02, {6'h0, st.busy, acc});
        wait_idle();
        chk("zero_addr_iso", 8'h01, {7'h0, st.isolated});
        write_ctrl(2'h0);
        repeat (8) @(posedge clk);
        chk("iso_early", 8'h01, {7'h0, st.isolated});
        repeat (13) @(posedge clk);
        chk("iso_clear", 8'h00, {7'h0, st.isolated});
        new_strap();
        write_ctrl(2'h1);
        repeat (3) @(posedge clk);
        chk("soft_busy", 8'h01, {7'h0, st.busy});
        wait_idle();
        chk("soft_iso_acc", 8'h00, {6'h0, st.isolated, acc});
        write_ctrl(2'h2);
        repeat (2) @(posedge clk);
        chk("iso_set", 8'h01, {7'h0, st.isolated});
        write_ctrl(2'h0);
        repeat (8) @(posedge clk);
        chk("iso_early_2", 8'h01, {7'h0, st.isolated});
        repeat (13) @(posedge clk);
        chk("iso_clear_2", 8'h00, {7'h0, st.isolated});
        chk("pending", 8'h00, 8'(exp_q.size()));
        finish_test();
    end
endmodule
`default_nettype wire
